// ---- hdl/ctr_cfg.svh ----
`ifndef CTR_CFG_SVH
`define CTR_CFG_SVH

// Register offsets
`define CTR_OFF_DATA 8'h00
`define CTR_OFF_STATUS 8'h04
`define CTR_OFF_CONTROL 8'h08

// Control field positions
`define CTR_CTL_EXT 19
`define CTR_CTL_TST_HI 18
`define CTR_CTL_TST_LO 17
`define CTR_CTL_IDX_HI 11
`define CTR_CTL_IDX_LO 4
`define CTR_CTL_ENT_HI 3
`define CTR_CTL_ENT_LO 2
`define CTR_CTL_OP_HI 1
`define CTR_CTL_OP_LO 0

// Status field positions
`define CTR_ST_TAG_HI 31
`define CTR_ST_TAG_LO 11
`define CTR_ST_VALID 10

// Reset values
`define CTR_LRU_RST 3'h0
`define CTR_IDX_RST 8'h00
`define CTR_TAG_RST 21'h000000
`define CTR_WORD_RST 32'h00000000

`endif

// ---- hdl/ctr_pkg.sv ----
package ctr_pkg;
  // Operation codes of the control field
  typedef enum logic [1:0] {
    OP_BUF = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2,
    OP_FLUSH = 2'h3
  } ctr_op_t;
  // Line states
  typedef enum logic [1:0] {
    LS_INVALID = 2'h0,
    LS_EXCLUSIVE = 2'h1,
    LS_MODIFIED = 2'h2,
    LS_SHARED = 2'h3
  } ctr_mesi_t;
endpackage

// ---- hdl/ctr_line_store.sv ----
`timescale 1ns/1ps
module ctr_line_store #(
  parameter int SETS = 256,
  parameter int WAYS = 4,
  parameter int TAG_W = 21,
  parameter int LINE_W = 128
) (
  // Clock
  input wire logic core_clk,
  // Address
  input wire logic [$clog2(SETS)-1:0] set_sel,
  input wire logic [$clog2(WAYS)-1:0] way_sel,
  // Write port
  input wire logic wr_en,
  input wire logic [TAG_W-1:0] tag_in,
  input wire logic [LINE_W-1:0] line_in,
  // Read port, combinational on the same address
  output logic [TAG_W-1:0] tag_out,
  output logic [LINE_W-1:0] line_out
);
  localparam int AW = $clog2(SETS) + $clog2(WAYS);
  logic [TAG_W-1:0] tag_mem [SETS*WAYS];
  logic [LINE_W-1:0] line_mem [SETS*WAYS];
  logic [AW-1:0] addr;

  // Tags and data need no reset; line state lives in flops outside
  assign addr = {set_sel, way_sel};
  assign tag_out = tag_mem[addr];
  assign line_out = line_mem[addr];

  // Write the selected entry
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      tag_mem[addr] <= tag_in;
      line_mem[addr] <= line_in;
    end
  end
endmodule // ctr_line_store

// ---- hdl/ctr_top.sv ----
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ctr_cfg.svh"
module ctr_top #(
  parameter int SETS = 256,
  parameter int TAG_W = 21
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Straps from pins
  input wire logic cache_policy_strap,
  input wire logic clock_multiplier_select,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Mode outputs
  output logic write_back_mode,
  output logic clock_tripled
);
  localparam int IW = $clog2(SETS);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // A line counts as valid in any state but invalid
  function automatic logic line_valid(input logic [1:0] st);
    return st != ctr_pkg::LS_INVALID;
  endfunction

  // Tree pseudo-LRU update after touching a way
  function automatic logic [2:0] plru_touch(input logic [2:0] lru, input logic [1:0] way);
    logic [2:0] r;
    r = lru;
    r[0] = ~way[1];
    if (!way[1]) begin
      r[1] = ~way[0];
    end else begin
      r[2] = ~way[0];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers

  logic [2:0] pol_s;
  logic [2:0] mul_s;
  logic pol_flt;
  logic mul_flt;
  logic next_pol_flt;
  logic next_mul_flt;
  logic next_write_back_mode;
  logic next_clock_tripled;

  // A strap level is taken only once stages two and three agree
  always_comb begin
    next_pol_flt = (pol_s[1] == pol_s[2]) ? pol_s[2] : pol_flt;
    next_mul_flt = (mul_s[1] == mul_s[2]) ? mul_s[2] : mul_flt;
  end

  // Chains run through reset so the level is settled when reset falls
  always_ff @(posedge core_clk) begin
    pol_s <= {pol_s[1:0], cache_policy_strap};
    mul_s <= {mul_s[1:0], clock_multiplier_select};
    pol_flt <= next_pol_flt;
    mul_flt <= next_mul_flt;
  end

  // Mode latches: the last reset cycle holds the sampled strap, later strap moves are ignored
  always_comb begin
    next_write_back_mode = sys_rst ? pol_flt : write_back_mode;
    next_clock_tripled = sys_rst ? mul_flt : clock_tripled;
  end

  always_ff @(posedge core_clk) begin
    write_back_mode <= next_write_back_mode;
    clock_tripled <= next_clock_tripled;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic wr_data;
  logic wr_status;
  logic wr_ctrl;
  ctr_pkg::ctr_op_t w_op;
  logic [IW-1:0] w_idx;
  logic [1:0] w_ent;
  logic [1:0] w_tst;
  logic do_read;
  logic do_write;
  logic do_flush;

  // New control fields act in the same cycle the write lands
  assign wr_data = reg_wr && (reg_addr == `CTR_OFF_DATA);
  assign wr_status = reg_wr && (reg_addr == `CTR_OFF_STATUS);
  assign wr_ctrl = reg_wr && (reg_addr == `CTR_OFF_CONTROL);
  assign w_op = ctr_pkg::ctr_op_t'(reg_wdata[`CTR_CTL_OP_HI:`CTR_CTL_OP_LO]);
  assign w_idx = reg_wdata[`CTR_CTL_IDX_HI:`CTR_CTL_IDX_LO];
  assign w_ent = reg_wdata[`CTR_CTL_ENT_HI:`CTR_CTL_ENT_LO];
  assign w_tst = reg_wdata[`CTR_CTL_TST_HI:`CTR_CTL_TST_LO];
  assign do_read = wr_ctrl && (w_op == ctr_pkg::OP_READ);
  assign do_write = wr_ctrl && (w_op == ctr_pkg::OP_WRITE);
  assign do_flush = wr_ctrl && (w_op == ctr_pkg::OP_FLUSH);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic ctl_ext;
  logic [1:0] ctl_tst;
  logic [IW-1:0] ctl_idx;
  logic [1:0] ctl_ent;
  ctr_pkg::ctr_op_t ctl_op;
  logic next_ctl_ext;
  logic [1:0] next_ctl_tst;
  logic [IW-1:0] next_ctl_idx;
  logic [1:0] next_ctl_ent;
  ctr_pkg::ctr_op_t next_ctl_op;
  logic ext_on;

  // Extension fields only exist in write-back mode
  always_comb begin
    next_ctl_ext = ctl_ext;
    next_ctl_tst = ctl_tst;
    next_ctl_idx = ctl_idx;
    next_ctl_ent = ctl_ent;
    next_ctl_op = ctl_op;
    if (wr_ctrl) begin
      next_ctl_op = w_op;
      next_ctl_ext = write_back_mode & reg_wdata[`CTR_CTL_EXT];
      if (w_op != ctr_pkg::OP_FLUSH) begin
        next_ctl_tst = write_back_mode ? w_tst : 2'h0;
        next_ctl_idx = w_idx;
        next_ctl_ent = w_ent;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_ext <= 1'b0;
      ctl_tst <= 2'h0;
      ctl_idx <= `CTR_IDX_RST;
      ctl_ent <= 2'h0;
      ctl_op <= ctr_pkg::OP_BUF;
    end else begin
      ctl_ext <= next_ctl_ext;
      ctl_tst <= next_ctl_tst;
      ctl_idx <= next_ctl_idx;
      ctl_ent <= next_ctl_ent;
      ctl_op <= next_ctl_op;
    end
  end

  // Layout select is void in write-through mode
  assign ext_on = write_back_mode & ctl_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Line state and LRU flops

  logic [3:0][1:0] line_state [SETS];
  logic [3:0][1:0] next_line_state [SETS];
  logic [2:0] lru [SETS];
  logic [2:0] next_lru [SETS];
  logic st_valid;
  logic [1:0] new_state;

  // Write-through has only valid or invalid, stored as exclusive or invalid
  always_comb begin
    if (write_back_mode) begin
      new_state = w_tst;
    end else begin
      new_state = st_valid ? ctr_pkg::LS_EXCLUSIVE : ctr_pkg::LS_INVALID;
    end
  end

  // Flush invalidates every line state and resets every LRU in one cycle, so it needs no busy phase; tags and data stay
  always_comb begin
    next_line_state = line_state;
    next_lru = lru;
    if (do_flush) begin
      for (int i = 0; i < SETS; i++) begin
        next_line_state[i] = '0;
        next_lru[i] = `CTR_LRU_RST;
      end
    end else if (do_write) begin
      next_line_state[w_idx][w_ent] = new_state;
      next_lru[w_idx] = plru_touch(lru[w_idx], w_ent);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < SETS; i++) begin
        line_state[i] <= '0;
        lru[i] <= `CTR_LRU_RST;
      end
    end else begin
      line_state <= next_line_state;
      lru <= next_lru;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tag and data store

  logic [TAG_W-1:0] mem_tag;
  logic [127:0] mem_line;
  logic [127:0] fill_line;
  logic [TAG_W-1:0] st_tag;
  logic [31:0] fill_buf [4];
  logic [31:0] read_buf [4];

  // Fill buffer doubleword k goes to bits 32k upward
  assign fill_line = {fill_buf[3], fill_buf[2], fill_buf[1], fill_buf[0]};

  ctr_line_store #(
    .SETS(SETS),
    .WAYS(4),
    .TAG_W(TAG_W),
    .LINE_W(128)
  ) u_store (
    .core_clk(core_clk),
    .set_sel(w_idx),
    .way_sel(w_ent),
    .wr_en(do_write),
    .tag_in(st_tag),
    .line_in(fill_line),
    .tag_out(mem_tag),
    .line_out(mem_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fill and read buffers

  logic [31:0] next_fill_buf [4];
  logic [31:0] next_read_buf [4];

  // Data writes outside buffer mode are dropped
  always_comb begin
    next_fill_buf = fill_buf;
    next_read_buf = read_buf;
    if (wr_data && (ctl_op == ctr_pkg::OP_BUF)) begin
      next_fill_buf[ctl_ent] = reg_wdata;
    end
    if (do_read) begin
      for (int k = 0; k < 4; k++) begin
        next_read_buf[k] = mem_line[32*k +: 32];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int k = 0; k < 4; k++) begin
        fill_buf[k] <= `CTR_WORD_RST;
        read_buf[k] <= `CTR_WORD_RST;
      end
    end else begin
      fill_buf <= next_fill_buf;
      read_buf <= next_read_buf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register

  logic [2:0] st_lru;
  logic [3:0] st_valids;
  logic [3:0][1:0] st_sets;
  logic [TAG_W-1:0] next_st_tag;
  logic next_st_valid;
  logic [2:0] next_st_lru;
  logic [3:0] next_st_valids;
  logic [3:0][1:0] next_st_sets;

  // Look-up snapshots the set; software may only touch tag and valid
  always_comb begin
    next_st_tag = st_tag;
    next_st_valid = st_valid;
    next_st_lru = st_lru;
    next_st_valids = st_valids;
    next_st_sets = st_sets;
    if (do_read) begin
      next_st_tag = mem_tag;
      next_st_lru = lru[w_idx];
      next_st_sets = line_state[w_idx];
      for (int k = 0; k < 4; k++) begin
        next_st_valids[k] = line_valid(line_state[w_idx][k]);
      end
      next_st_valid = line_valid(line_state[w_idx][w_ent]);
    end else if (wr_status) begin
      if (!ext_on) begin
        next_st_tag = reg_wdata[`CTR_ST_TAG_HI:`CTR_ST_TAG_LO];
      end
      if (!write_back_mode) begin
        next_st_valid = reg_wdata[`CTR_ST_VALID];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_tag <= `CTR_TAG_RST;
      st_valid <= 1'b0;
      st_lru <= `CTR_LRU_RST;
      st_valids <= 4'h0;
      st_sets <= '0;
    end else begin
      st_tag <= next_st_tag;
      st_valid <= next_st_valid;
      st_lru <= next_st_lru;
      st_valids <= next_st_valids;
      st_sets <= next_st_sets;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  logic [31:0] status_word;
  logic [31:0] control_word;
  logic [31:0] rd_mux;

  // Unused and reserved bits stay zero
  always_comb begin
    status_word = `CTR_WORD_RST;
    if (ext_on) begin
      status_word[30:29] = st_sets[ctl_tst];
      status_word[27:20] = st_sets;
    end else begin
      status_word[`CTR_ST_TAG_HI:`CTR_ST_TAG_LO] = st_tag;
    end
    status_word[`CTR_ST_VALID] = st_valid;
    status_word[9:7] = st_lru;
    status_word[6:3] = st_valids;
  end

  always_comb begin
    control_word = `CTR_WORD_RST;
    control_word[`CTR_CTL_EXT] = ctl_ext;
    control_word[`CTR_CTL_TST_HI:`CTR_CTL_TST_LO] = ctl_tst;
    control_word[`CTR_CTL_IDX_HI:`CTR_CTL_IDX_LO] = ctl_idx;
    control_word[`CTR_CTL_ENT_HI:`CTR_CTL_ENT_LO] = ctl_ent;
    control_word[`CTR_CTL_OP_HI:`CTR_CTL_OP_LO] = ctl_op;
  end

  // Unmapped offsets answer zero rather than stall the master
  always_comb begin
    case (reg_addr)
      `CTR_OFF_DATA: rd_mux = read_buf[ctl_ent];
      `CTR_OFF_STATUS: rd_mux = status_word;
      `CTR_OFF_CONTROL: rd_mux = control_word;
      default: rd_mux = `CTR_WORD_RST;
    endcase
  end

  // Read data stand for exactly the one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= `CTR_WORD_RST;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `CTR_WORD_RST;
    end
  end
endmodule // ctr_top

// ---- test/ctr_top_monitor.sv ----
`timescale 1ns/1ps
module ctr_top_monitor #(
  parameter int SETS = 256,
  parameter int TAG_W = 21
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Straps
  input wire logic cache_policy_strap,
  input wire logic clock_multiplier_select,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Mode outputs
  input wire logic write_back_mode,
  input wire logic clock_tripled
);
  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data only in the answer cycle, holes and reserved bits read zero
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(reg_rd) |-> reg_rdata == 32'h00000000) else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && !(reg_addr inside {8'h00, 8'h04, 8'h08}) |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == 8'h08 |=> reg_rdata[31:20] == 12'h000 && reg_rdata[16:12] == 5'h00)
    else $error("control reserved bits set");
  a_wt_ext_hidden: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == 8'h08 && !write_back_mode |=> reg_rdata[19:17] == 3'h0)
    else $error("write-back fields seen in write-through");
  a_status_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[2:0] == 3'h0) else $error("status unused bits set");
  // Index, entry and operation read back as written, flush excepted
  a_ctl_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_addr == 8'h08 && reg_wdata[1:0] != 2'h3 ##2 reg_rd && reg_addr == 8'h08
    |=> reg_rdata[11:0] == $past(reg_wdata[11:0], 3)) else $error("control fields lost");
  ////////////////////////////////////////////////////////////////////////////////
  // Modes follow the straps held through reset and then stand
  a_mode_stands: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(write_back_mode)) else $error("cache mode changed");
  a_triple_stands: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(clock_tripled)) else $error("clock mode changed");
  a_mode_strap: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(sys_rst) && $past(cache_policy_strap, 5) == cache_policy_strap
    |-> write_back_mode == cache_policy_strap) else $error("cache mode not from strap");
  a_triple_strap: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(sys_rst) && $past(clock_multiplier_select, 5) == clock_multiplier_select
    |-> clock_tripled == clock_multiplier_select) else $error("clock mode not from pin");
  // Main scenarios
  c_flush: cover property (@(posedge core_clk) reg_wr && reg_addr == 8'h08 && reg_wdata[1:0] == 2'h3);
  c_wb_status: cover property (@(posedge core_clk) reg_rd && reg_addr == 8'h04 && write_back_mode);
  c_wt_write: cover property (@(posedge core_clk) reg_wr && reg_addr == 8'h08 && !write_back_mode);
endmodule // ctr_top_monitor

bind ctr_top ctr_top_monitor #(.SETS(SETS), .TAG_W(TAG_W)) mon_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .cache_policy_strap(cache_policy_strap), .clock_multiplier_select(clock_multiplier_select),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .write_back_mode(write_back_mode), .clock_tripled(clock_tripled));

// ---- test/ctr_cpu_model.sv ----
`timescale 1ns/1ps
module ctr_cpu_model (
  // Clock
  input wire logic core_clk,
  // Register port towards the block
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    reg_addr = 8'hFF;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write; released lines carry the inverse so stale values never pass for data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One-cycle read; data stand only in the following cycle, taken mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule // ctr_cpu_model

// ---- test/tb_cache_test_register_access.sv ----
`timescale 1ns/1ps
module tb_cache_test_register_access;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cache_policy_strap = 1'b1;
  logic clock_multiplier_select = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic write_back_mode;
  logic clock_tripled;
  logic [31:0] d;
  int mismatches = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  ctr_top #(.SETS(256), .TAG_W(21)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .cache_policy_strap(cache_policy_strap), .clock_multiplier_select(clock_multiplier_select),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .write_back_mode(write_back_mode), .clock_tripled(clock_tripled));
  ctr_cpu_model cpu_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: line data and tags are tied to the way so a wrong way shows up
  function automatic logic [31:0] dw(input int w, input int k);
    return {24'hD00000, 2'h0, w[1:0], 2'h0, k[1:0]};
  endfunction
  function automatic logic [20:0] tg(input int w);
    return {17'h1A5C3, 2'h0, w[1:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wctl(input logic ext, input logic [1:0] tst, input logic [7:0] idx, input logic [1:0] ent,
                      input logic [1:0] op);
    cpu_u.wr(8'h08, {12'h000, ext, tst, 1'b0, 4'h0, idx, ent, op});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    cpu_u.rd(a, v);
    chk(v, exp);
  endtask
  // Fill the buffer, load tag with junk in bits 9:0, then write the way
  task automatic cwrite(input int w, input logic [1:0] st, input logic [7:0] idx, input logic v);
    for (int k = 0; k < 4; k++) begin
      wctl(1'b0, 2'h0, 8'h00, k[1:0], 2'h0);
      cpu_u.wr(8'h00, dw(w, k));
    end
    cpu_u.wr(8'h04, {tg(w), v, 10'h3FF});
    wctl(1'b0, st, idx, w[1:0], 2'h1);
  endtask
  task automatic rbuf(input int w, input logic [7:0] idx);
    for (int k = 0; k < 4; k++) begin
      wctl(1'b0, 2'h0, idx, k[1:0], 2'h0);
      rchk(8'h00, dw(w, k));
    end
  endtask
  // Straps settle before reset so the sync chain sees them
  task automatic do_reset(input logic wb, input logic mul);
    @(posedge core_clk);
    cache_policy_strap <= wb;
    clock_multiplier_select <= mul;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
  // Main sequence: write-back run, then write-through run with tripled clock
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk({30'h0, write_back_mode, clock_tripled}, 32'h00000002);
    wctl(1'b1, 2'h0, 8'hA5, 2'h3, 2'h2);
    rchk(8'h04, 32'h00000000);
    for (int w = 3; w >= 0; w--) cwrite(w, w[1:0], 8'hA5, 1'b1);
    wctl(1'b0, 2'h0, 8'hA5, 2'h3, 2'h2);
    rchk(8'h04, {tg(3), 1'b1, 3'h7, 4'hE, 3'h0});
    rbuf(3, 8'hA5);
    wctl(1'b0, 2'h0, 8'hA5, 2'h1, 2'h2);
    rbuf(1, 8'hA5);
    wctl(1'b1, 2'h0, 8'hA4, 2'h3, 2'h2);
    rchk(8'h04, 32'h00000000);
    for (int t = 0; t < 4; t++) begin
      wctl(1'b1, t[1:0], 8'hA5, 2'h3, 2'h2);
      rchk(8'h04, {1'b0, t[1:0], 1'b0, 8'hE4, 9'h000, 1'b1, 3'h7, 4'hE, 3'h0});
    end
    wctl(1'b1, 2'h0, 8'h00, 2'h0, 2'h3);
    rchk(8'h08, {12'h000, 1'b1, 2'h3, 1'b0, 4'h0, 8'hA5, 2'h3, 2'h3});
    wctl(1'b1, 2'h0, 8'hA5, 2'h3, 2'h2);
    rchk(8'h04, 32'h00000000);
    rchk(8'h0C, 32'h00000000);
    do_reset(1'b0, 1'b1);
    @(negedge core_clk);
    chk({30'h0, write_back_mode, clock_tripled}, 32'h00000001);
    cpu_u.wr(8'h04, {21'h0ABCD, 1'b1, 10'h3FF});
    rchk(8'h04, {21'h0ABCD, 1'b1, 10'h000});
    wctl(1'b1, 2'h3, 8'h3C, 2'h1, 2'h0);
    rchk(8'h08, {20'h00000, 8'h3C, 2'h1, 2'h0});
    cwrite(1, 2'h3, 8'h3C, 1'b1);
    cwrite(2, 2'h3, 8'h3C, 1'b0);
    wctl(1'b0, 2'h0, 8'h3C, 2'h1, 2'h2);
    rchk(8'h04, {tg(1), 1'b1, 3'h4, 4'h2, 3'h0});
    wctl(1'b0, 2'h0, 8'h3C, 2'h2, 2'h2);
    rchk(8'h04, {tg(2), 1'b0, 3'h4, 4'h2, 3'h0});
    rbuf(2, 8'h3C);
    wctl(1'b0, 2'h0, 8'h00, 2'h0, 2'h3);
    wctl(1'b0, 2'h0, 8'h3C, 2'h1, 2'h2);
    cpu_u.rd(8'h04, d);
    chk({21'h000000, d[10:0]}, 32'h00000000);
    print_verdict();
  end
endmodule // tb_cache_test_register_access
